// [wdtb_consts.vh]
// Constants shared by the watchdog timer block.
// What this block does
// RULE1: Reset the device when the count reaches the period without a clear.
// RULE2: Count low-frequency oscillator edges; period steps are 1 ms ticks.
// RULE3: Mode 11 keeps the watchdog active always, also in Sleep.
// RULE4: Mode 10 keeps it active while awake, disabled in Sleep.
// RULE5: Mode 01 follows the software enable bit; Sleep changes nothing.
// RULE6: Mode 00 keeps the watchdog disabled always.
// RULE7: The period select field picks a period from 1 ms to 256 s.
// RULE8: After any reset the period select gives a 2 s period.
// RULE9: Reset, clear, Sleep entry or exit, oscillator fail, disable clear it.
// RULE10: Changing the internal oscillator divider does not touch the count.
// RULE11: In Sleep it restarts from zero and is cleared again on wake.
// RULE12: A time-out in Sleep wakes the device instead of resetting it.
// RULE13: A time-out updates the timeout and powerdown status flags.
// RULE14: Each period select step doubles the period, saturating at 256 s.
// RULE15: Clears and oscillator edges cross safely so none is lost.
`ifndef WDTB_CONSTS_VH
`define WDTB_CONSTS_VH

`define WDTB_CLK_HZ 20000000
`define WDTB_LF_HZ 31000
`define WDTB_TICK_MS 1
// Oscillator edges per 1 ms tick, from the nominal rate.
`define WDTB_LF_PER_MS ((`WDTB_LF_HZ * `WDTB_TICK_MS) / 1000)

`define WDTB_SEL_W 5
`define WDTB_SEL_MAX 5'h12
`define WDTB_SEL_RST 5'h0b
`define WDTB_MS_W 19

`define WDTB_MODE_OFF 2'h0
`define WDTB_MODE_SW 2'h1
`define WDTB_MODE_AWAKE 2'h2
`define WDTB_MODE_ON 2'h3

`define WDTB_OFF_CTRL 8'h00
`define WDTB_OFF_CPUST 8'h04
`define WDTB_OFF_IRQST 8'h08
`define WDTB_OFF_IRQMSK 8'h0c
`define WDTB_OFF_COUNT 8'h10

`define WDTB_CTRL_EN 0
`define WDTB_CTRL_SEL_LO 1
`define WDTB_CTRL_SEL_HI 5
`define WDTB_ST_TIMEOUT 0
`define WDTB_ST_PWRDN 1
`define WDTB_ST_ACTIVE 2
`define WDTB_EV_TIMEOUT 0
`define WDTB_EV_WAKE 1
`define WDTB_EV_W 2

`endif

// [wdtb_sync.v]
// Two-stage synchroniser with rising-edge detect for the oscillator pin.
`timescale 1ns/100ps
`default_nettype none
module wdtb_sync (
	input wire i_clk,
	input wire i_rst_n,
	input wire i_async,
	output wire o_rise
);
	reg meta_r;
	reg sync_r;
	reg last_r;

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			last_r <= 1'b0;
		end else begin
			meta_r <= i_async;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	// Only the second stage feeds the edge detect.
	assign o_rise = sync_r & ~last_r; // see RULE15
endmodule
`default_nettype wire

// [wdtb_cnt.v]
// Prescaler and millisecond counter that flag a watchdog expiry.
`timescale 1ns/100ps
`default_nettype none
`include "wdtb_consts.vh"
module wdtb_cnt #(
	parameter LF_PER_MS = 31,
	parameter PRE_W = 5
) (
	input wire i_clk,
	input wire i_rst_n,
	input wire i_lf_rise,
	input wire i_clear,
	input wire i_run,
	input wire [`WDTB_SEL_W-1:0] i_sel,
	output reg o_expire,
	output reg [`WDTB_MS_W-1:0] o_ms_cnt
);
	localparam integer PRE_LAST_I = LF_PER_MS - 1;
	localparam [PRE_W-1:0] PRE_LAST = PRE_LAST_I[PRE_W-1:0];
	reg [PRE_W-1:0] pre_r;
	wire ms_tick;

	function [`WDTB_MS_W-1:0] last_ms;
		input [`WDTB_SEL_W-1:0] sel;
		reg [`WDTB_SEL_W-1:0] s;
		begin
			s = (sel > `WDTB_SEL_MAX) ? `WDTB_SEL_MAX : sel; // see RULE14
			last_ms = ({{(`WDTB_MS_W-1){1'b0}}, 1'b1} << s) -
				{{(`WDTB_MS_W-1){1'b0}}, 1'b1}; // see RULE7
		end
	endfunction

	assign ms_tick = i_run & i_lf_rise & (pre_r == PRE_LAST); // see RULE2

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			pre_r <= {PRE_W{1'b0}};
			o_ms_cnt <= {`WDTB_MS_W{1'b0}};
			o_expire <= 1'b0;
		end else if (i_clear || !i_run) begin
			pre_r <= {PRE_W{1'b0}}; // see RULE9
			o_ms_cnt <= {`WDTB_MS_W{1'b0}};
			o_expire <= 1'b0;
		end else begin
			o_expire <= 1'b0;
			if (i_lf_rise) begin
				pre_r <= (pre_r == PRE_LAST) ? {PRE_W{1'b0}} : pre_r + 1'b1;
			end
			if (ms_tick) begin
				if (o_ms_cnt == last_ms(i_sel)) begin
					o_ms_cnt <= {`WDTB_MS_W{1'b0}};
					o_expire <= 1'b1; // see RULE1
				end else begin
					o_ms_cnt <= o_ms_cnt + 1'b1;
				end
			end
		end
	end
endmodule
`default_nettype wire

// [wdtb_top.v]
// Watchdog timer top level with its AHB-Lite register slave.
//
// Chosen here: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "wdtb_consts.vh"
module wdtb_top #(
	parameter LF_PER_MS = `WDTB_LF_PER_MS
) (
	input wire i_clk,
	input wire i_rst_n,
	input wire i_low_freq_osc,
	input wire [1:0] i_wdt_mode_cfg,
	input wire i_clear_watchdog_instr,
	input wire i_sleep,
	input wire i_osc_fail,
	input wire i_hsel,
	input wire [31:0] i_haddr,
	input wire [1:0] i_htrans,
	input wire i_hwrite,
	input wire [2:0] i_hsize,
	input wire [31:0] i_hwdata,
	input wire i_hready,
	output wire [31:0] o_hrdata,
	output wire o_hreadyout,
	output wire o_hresp,
	output reg o_wdt_reset,
	output reg o_wake,
	output wire o_irq
);
	reg sw_wdt_enable_r;
	reg [`WDTB_SEL_W-1:0] wdt_period_select_r;
	reg timeout_flag_r;
	reg powerdown_flag_r;
	reg [`WDTB_EV_W-1:0] irq_st_r;
	reg [`WDTB_EV_W-1:0] irq_msk_r;
	reg sleep_q_r;
	reg active_q_r;
	reg wr_pend_r;
	reg [7:0] wr_addr_r;
	reg [31:0] rdata_r;
	reg active_nxt;
	reg [31:0] rdata_nxt;
	wire lf_rise;
	wire expire;
	wire [`WDTB_MS_W-1:0] ms_cnt;
	wire sleep_enter;
	wire sleep_exit;
	wire wdt_clear;
	wire addr_phase;
	wire [`WDTB_EV_W-1:0] ev_set;
	wire [`WDTB_EV_W-1:0] ev_clr;

	wdtb_sync u_sync (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_async(i_low_freq_osc),
		.o_rise(lf_rise)
	);

	// Operating mode decode from the configuration field.
	always @* begin
		case (i_wdt_mode_cfg)
		`WDTB_MODE_ON: begin
			active_nxt = 1'b1; // see RULE3
		end
		`WDTB_MODE_AWAKE: begin
			active_nxt = ~i_sleep; // see RULE4
		end
		`WDTB_MODE_SW: begin
			active_nxt = sw_wdt_enable_r; // see RULE5
		end
		default: begin
			active_nxt = 1'b0; // see RULE6
		end
		endcase
	end

	assign sleep_enter = i_sleep & ~sleep_q_r;
	assign sleep_exit = ~i_sleep & sleep_q_r;
	// The core clock drives both the clear strobe and the counter, so the
	// clear is seen in the same cycle and cannot be dropped; the divider
	// setting of the internal oscillator is not an input here at all.
	assign wdt_clear = i_clear_watchdog_instr | sleep_enter | sleep_exit |
		i_osc_fail | (active_q_r & ~active_nxt); // see RULE9 RULE10 RULE15

	wdtb_cnt #(
		.LF_PER_MS(LF_PER_MS)
	) u_cnt (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_lf_rise(lf_rise),
		.i_clear(wdt_clear), // see RULE11
		.i_run(active_nxt),
		.i_sel(wdt_period_select_r),
		.o_expire(expire),
		.o_ms_cnt(ms_cnt)
	);

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sleep_q_r <= 1'b0;
			active_q_r <= 1'b0;
			o_wdt_reset <= 1'b0;
			o_wake <= 1'b0;
		end else begin
			sleep_q_r <= i_sleep;
			active_q_r <= active_nxt;
			o_wdt_reset <= expire & ~sleep_q_r; // see RULE1
			o_wake <= expire & sleep_q_r; // see RULE12
		end
	end

	// Status flags survive the watchdog reset so software can see why it
	// restarted; only the block reset, a clear strobe or, for the powerdown flag, an expiry while awake clears them.
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			timeout_flag_r <= 1'b0;
			powerdown_flag_r <= 1'b0;
		end else begin
			if (expire) begin
				timeout_flag_r <= 1'b1; // see RULE13
			end else if (i_clear_watchdog_instr) begin
				timeout_flag_r <= 1'b0;
			end
			if (expire || sleep_enter) begin
				powerdown_flag_r <= sleep_q_r | sleep_enter; // see RULE13
			end else if (i_clear_watchdog_instr) begin
				powerdown_flag_r <= 1'b0;
			end
		end
	end

	// AHB-Lite slave: zero wait states, always OKAY.
	assign addr_phase = i_hsel & i_hready & i_htrans[1];
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_hrdata = rdata_r;

	always @* begin
		rdata_nxt = 32'h0000_0000;
		case (i_haddr[7:0])
		`WDTB_OFF_CTRL: begin
			rdata_nxt[`WDTB_CTRL_EN] = sw_wdt_enable_r;
			rdata_nxt[`WDTB_CTRL_SEL_HI:`WDTB_CTRL_SEL_LO] =
				wdt_period_select_r;
		end
		`WDTB_OFF_CPUST: begin
			rdata_nxt[`WDTB_ST_TIMEOUT] = timeout_flag_r;
			rdata_nxt[`WDTB_ST_PWRDN] = powerdown_flag_r;
			rdata_nxt[`WDTB_ST_ACTIVE] = active_q_r;
		end
		`WDTB_OFF_IRQST: begin
			rdata_nxt[`WDTB_EV_W-1:0] = irq_st_r;
		end
		`WDTB_OFF_IRQMSK: begin
			rdata_nxt[`WDTB_EV_W-1:0] = irq_msk_r;
		end
		`WDTB_OFF_COUNT: begin
			rdata_nxt[`WDTB_MS_W-1:0] = ms_cnt;
		end
		default: begin
			rdata_nxt = 32'h0000_0000;
		end
		endcase
		if (|i_haddr[31:8]) begin
			rdata_nxt = 32'h0000_0000;
		end
	end

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			rdata_r <= 32'h0000_0000;
		end else begin
			wr_pend_r <= addr_phase & i_hwrite & ~(|i_haddr[31:8]);
			if (addr_phase) begin
				wr_addr_r <= i_haddr[7:0];
			end
			if (addr_phase && !i_hwrite) begin
				rdata_r <= rdata_nxt;
			end
		end
	end

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sw_wdt_enable_r <= 1'b0;
			wdt_period_select_r <= `WDTB_SEL_RST; // see RULE8
			irq_msk_r <= {`WDTB_EV_W{1'b0}};
		end else if (wr_pend_r) begin
			if (wr_addr_r == `WDTB_OFF_CTRL) begin
				sw_wdt_enable_r <= i_hwdata[`WDTB_CTRL_EN];
				wdt_period_select_r <=
					i_hwdata[`WDTB_CTRL_SEL_HI:`WDTB_CTRL_SEL_LO];
			end
			if (wr_addr_r == `WDTB_OFF_IRQMSK) begin
				irq_msk_r <= i_hwdata[`WDTB_EV_W-1:0];
			end
		end
	end

	// Interrupt events; a new event in the clearing cycle stays set.
	assign ev_set = {o_wake, expire};
	assign ev_clr = (wr_pend_r && wr_addr_r == `WDTB_OFF_IRQST) ?
		i_hwdata[`WDTB_EV_W-1:0] : {`WDTB_EV_W{1'b0}};

	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			irq_st_r <= {`WDTB_EV_W{1'b0}};
		end else begin
			irq_st_r <= (irq_st_r & ~ev_clr) | ev_set;
		end
	end

	assign o_irq = |(irq_st_r & irq_msk_r);
endmodule
`default_nettype wire

// [wdtb_chk.sv]
// Port timing checker for the watchdog top level.
`timescale 1ns/100ps
`default_nettype none
module wdtb_chk (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_low_freq_osc,
	input wire logic [1:0] i_wdt_mode_cfg,
	input wire logic i_clear_watchdog_instr,
	input wire logic i_sleep,
	input wire logic i_osc_fail,
	input wire logic o_hreadyout,
	input wire logic o_hresp,
	input wire logic o_wdt_reset,
	input wire logic o_wake
);
	logic [3:0] age_r;
	wire hit = o_wdt_reset || o_wake;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	// An expiry must follow a fresh oscillator rise, never a falling edge.
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n)
			age_r <= 4'hf;
		else if ($rose(i_low_freq_osc))
			age_r <= 4'h0;
		else if (age_r != 4'hf)
			age_r <= age_r + 4'h1;
	end
	property p_bus; o_hreadyout && !o_hresp; endproperty
	a_bus: assert property (p_bus)
		else $error("bus not ready");
	property p_pls; o_wdt_reset |=> !o_wdt_reset; endproperty
	a_pls: assert property (p_pls)
		else $error("reset pulse too long");
	property p_wpl; o_wake |=> !o_wake; endproperty
	a_wpl: assert property (p_wpl)
		else $error("wake pulse too long");
	// The outputs are registered from the expiry, itself registered, so the
	// inputs that decided them lie two edges back.
	property p_slp; o_wdt_reset |-> !$past(i_sleep, 2); endproperty
	a_slp: assert property (p_slp)
		else $error("reset in sleep");
	property p_wk;
		o_wake |-> $past(i_sleep, 2) && $past(i_wdt_mode_cfg, 2) != 2'h2;
	endproperty
	a_wk: assert property (p_wk)
		else $error("bad wake");
	property p_off; hit |-> $past(i_wdt_mode_cfg, 2) != 2'h0; endproperty
	a_off: assert property (p_off)
		else $error("expiry while off");
	property p_clr;
		hit |-> !$past(i_clear_watchdog_instr, 2) && !$past(i_osc_fail, 2);
	endproperty
	a_clr: assert property (p_clr)
		else $error("expiry despite clear");
	property p_osc; hit |-> age_r < 4'h8; endproperty
	a_osc: assert property (p_osc)
		else $error("expiry without osc edge");
endmodule
bind wdtb_top wdtb_chk wdtb_chk_inst (.i_clk, .i_rst_n, .i_low_freq_osc,
	.i_wdt_mode_cfg, .i_clear_watchdog_instr, .i_sleep, .i_osc_fail,
	.o_hreadyout, .o_hresp, .o_wdt_reset, .o_wake);
`default_nettype wire

// [wdtb_core.sv]
// Behavioural core: sleeps on request, wakes on expiry, kicks on request.
`timescale 1ns/100ps
`default_nettype none
module wdtb_core (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_sleep_req,
	input wire logic i_kick,
	input wire logic i_wake,
	output logic o_sleep,
	output logic o_clear
);
	logic woke_r;
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			o_sleep <= 1'b0;
			o_clear <= 1'b0;
			woke_r <= 1'b0;
		end else begin
			// A wake ends Sleep until software asks for Sleep again.
			woke_r <= i_sleep_req && (woke_r || i_wake);
			o_sleep <= i_sleep_req && !woke_r && !i_wake;
			// Strobes last one cycle, so a held kick clears every other cycle.
			o_clear <= i_kick && !o_clear;
		end
	end
endmodule
`default_nettype wire

// [watchdog_timer_block_tb_top.sv]
// Self-checking bench of the watchdog timer block.
`timescale 1ns/100ps
`default_nettype none
module watchdog_timer_block_tb_top;
	localparam int LF = 2;
	logic clk = '0, rst_n = '0, osc = '0, hsel = '0, hwrite = '0;
	logic kick = '0, fail = '0, sreq = '0;
	logic [1:0] htrans = '0, mode = '0;
	logic [31:0] haddr = '0, hwdata = '0, q;
	wire [31:0] hrdata;
	wire rdy, resp, wrst, wake, irq, slp, clr;
	int fail_count = 0, num_checks = 0, seed = 41185;
	always #25 clk = ~clk;
	initial begin
		#13;
		forever #500 osc = ~osc;
	end
	wdtb_top #(.LF_PER_MS(LF)) wdtb_top_inst (.i_clk(clk), .i_rst_n(rst_n),
		.i_low_freq_osc(osc), .i_wdt_mode_cfg(mode),
		.i_clear_watchdog_instr(clr), .i_sleep(slp), .i_osc_fail(fail),
		.i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(rdy), .o_hrdata(hrdata),
		.o_hreadyout(rdy), .o_hresp(resp), .o_wdt_reset(wrst), .o_wake(wake),
		.o_irq(irq));
	wdtb_core wdtb_core_inst (.i_clk(clk), .i_rst_n(rst_n), .i_sleep_req(sreq),
		.i_kick(kick), .i_wake(wake), .o_sleep(slp), .o_clear(clr));
	task chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge clk);
		while (rdy !== 1'b1)
			@(posedge clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (rdy !== 1'b1)
			@(posedge clk);
		q = hrdata;
	endtask
	task run(input logic [1:0] m, input logic en, s, input int k, h);
		int n, got, e;
		logic p;
		logic [4:0] sel;
		logic [1:0] msk;
		sel = 5'($random(seed) & 3);
		msk = 2'($random(seed));
		e = LF << sel;
		bus(1'b1, 8'h0c, {30'h0, msk});
		bus(1'b1, 8'h00, {26'h0, sel, en});
		// Start away from an oscillator rise so the first edge is whole.
		@(negedge osc);
		@(posedge clk);
		mode <= m;
		kick <= 1'b1;
		fail <= h == 2;
		@(posedge clk);
		kick <= h == 1;
		sreq <= s;
		n = 0;
		got = 0;
		p = osc;
		while (got == 0 && n <= e + 1) begin
			@(negedge clk);
			if (osc && !p)
				n++;
			p = osc;
			if (wrst === 1'b1)
				got = 1;
			if (wake === 1'b1)
				got = 2;
		end
		@(posedge clk);
		mode <= 2'h0;
		sreq <= 1'b0;
		kick <= 1'b0;
		fail <= 1'b0;
		chk(got, k);
		if (k != 0) begin
			chk(n, e);
			bus(1'b0, 8'h04, '0);
			chk(q, 1 + 2 * s);
			bus(1'b0, 8'h08, '0);
			chk(q, {30'h0, k == 2, 1'b1});
			chk(irq, |({k == 2, 1'b1} & msk));
			bus(1'b1, 8'h08, 32'h0000_0003);
			bus(1'b0, 8'h08, '0);
			chk(q, '0);
			chk(irq, '0);
		end
		$display("test mode %0d sleep %0d done", m, s);
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		bus(1'b0, 8'h00, '0);
		chk(q, 32'h0000_0016);
		bus(1'b1, 8'h20, 32'hffff_ffff);
		bus(1'b0, 8'h20, '0);
		chk(q, '0);
		run(2'h3, 0, 0, 1, 0);
		run(2'h3, 0, 1, 2, 0);
		run(2'h2, 0, 0, 1, 0);
		run(2'h2, 1, 1, 0, 0);
		run(2'h1, 1, 1, 2, 0);
		run(2'h1, 0, 0, 0, 0);
		run(2'h0, 1, 1, 0, 0);
		run(2'h3, 1, 0, 0, 1);
		run(2'h3, 1, 0, 0, 2);
		// A second reset after the last run must restore the defaults.
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		bus(1'b0, 8'h00, '0);
		chk(q, 32'h0000_0016);
		@(posedge clk);
		mode <= 2'h3;
		bus(1'b0, 8'h04, '0);
		chk(q, 32'h0000_0004);
		bus(1'b0, 8'h10, '0);
		chk(q, '0);
		mode <= 2'h0;
		$display("test reset done");
		stop_test;
	end
	initial begin
		#1000000;
		fail_count++;
		stop_test;
	end
endmodule
`default_nettype wire
